//--- ack_counter.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// acknowledge delay counter, cleared whenever select drops
// ------------------------------------------------------------
module ack_counter
  import dpram_arb_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic long_i,
  // status
  output logic done_o
);
  logic [ACK_CNT_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic [ACK_CNT_W-1:0] limit;

  always_comb begin
    limit = long_i ? ACK_COUNT_LONG : ACK_COUNT_SHORT;
    cnt_d = cnt_q;
    done_d = done_q;
    if (!run_i) begin
      cnt_d = ACK_COUNT_ZERO;
      done_d = 1'b0;
    // done is raised as the count reaches one below the limit so that the registered
    // acknowledge follows on the very next edge, not one edge later
    end else if (cnt_q < (limit - ACK_COUNT_ONE)) begin
      cnt_d = cnt_q + ACK_COUNT_ONE;
    end else begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_q <= ACK_COUNT_ZERO;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
endmodule

//--- dpram_arb_pkg.sv
package dpram_arb_pkg;
  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int BLOCK_W = 10;
  localparam int BLOCK_SEL_W = ADDR_W - BLOCK_W;
  localparam logic [BLOCK_SEL_W-1:0] CPU_BLOCK_BASE = 10'h003;
  localparam logic [BLOCK_SEL_W-1:0] CPU_BLOCK_EXP = 10'h007;
  // ------------------------------------------------------------
  // acknowledge timing
  // ------------------------------------------------------------
  localparam int ACK_CNT_W = 6;
  localparam logic [ACK_CNT_W-1:0] ACK_COUNT_SHORT = 6'h02;
  localparam logic [ACK_CNT_W-1:0] ACK_COUNT_LONG = 6'h22;
  localparam logic [ACK_CNT_W-1:0] ACK_COUNT_ZERO = 6'h00;
  localparam logic [ACK_CNT_W-1:0] ACK_COUNT_ONE = 6'h01;
  localparam real CLK_MHZ = 18.432;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SLAVE,
    ST_LOCAL
  } arb_state_type;
endpackage

//--- dual_port_ram_arbiter.sv
`timescale 1ns/10ps
module dual_port_ram_arbiter
  import dpram_arb_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // configuration
  input wire logic expansion_fitted_i,
  input wire logic long_ack_i,
  input wire logic [BLOCK_SEL_W-1:0] sys_window_block_i,
  // cpu side
  input wire logic [ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_mem_cmd_n_i,
  input wire logic early_mem_write_n,
  // system bus side
  input wire logic [ADDR_W-1:0] sys_addr_i,
  input wire logic sys_mrdc_n_i,
  input wire logic sys_mwtc_n_i,
  input wire logic sys_inh2_n_i,
  input wire logic own_master_address_drive_n,
  // system bus outputs
  output logic sys_inh1_n_o,
  output logic ack_driver_enable_n_o,
  output logic shared_ram_sys_ack_n_o,
  output logic sys_data_buffer_enable_n_o,
  output logic sys_data_direction_n_o,
  // shared ram and drivers
  output logic slave_address_drive_n_o,
  output logic local_address_drive_n_o,
  output logic shared_ram_select_n_o,
  output logic shared_ram_write_enable_n_o,
  // cpu outputs
  output logic cpu_shared_ram_ack_n_o,
  output logic cpu_window_request_o
);
  // ------------------------------------------------------------
  // window decode
  // ------------------------------------------------------------
  function automatic logic in_block(input logic [ADDR_W-1:0] a,
                                    input logic [BLOCK_SEL_W-1:0] blk);
    in_block = (a[ADDR_W-1:BLOCK_W] == blk);
  endfunction

  logic cpu_window_request;
  logic sys_window_request;
  logic sys_cmd;
  logic ack_done;

  always_comb begin
    cpu_window_request = !cpu_mem_cmd_n_i &&
      in_block(cpu_addr_i, expansion_fitted_i ? CPU_BLOCK_EXP : CPU_BLOCK_BASE);
    sys_cmd = !sys_mrdc_n_i || !sys_mwtc_n_i;
    sys_window_request = sys_cmd && in_block(sys_addr_i, sys_window_block_i)
      && own_master_address_drive_n
      && sys_inh2_n_i;
  end

  // ------------------------------------------------------------
  // arbitration state
  // ------------------------------------------------------------
  arb_state_type state_q, state_d;
  logic pend_q, pend_d;
  logic sel_q, sel_d;
  logic ack_en_q, ack_en_d;
  logic xack_q, xack_d;
  logic dir_q, dir_d;
  logic we_q, we_d;
  logic lack_q, lack_d;
  logic inh1_q, inh1_d;

  always_comb begin
    state_d = state_q;
    pend_d = pend_q;
    sel_d = sel_q;
    ack_en_d = ack_en_q;
    xack_d = 1'b0;
    dir_d = dir_q;
    we_d = 1'b0;
    lack_d = 1'b0;
    inh1_d = sys_window_request;
    // pending flag set by window request, cleared one edge after command removal
    if (sys_window_request) begin
      pend_d = 1'b1;
    end else if (!sys_cmd) begin
      pend_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        sel_d = 1'b0;
        ack_en_d = 1'b0;
        if (cpu_window_request) begin
          // cpu has priority even with a pending system access
          state_d = ST_LOCAL;
          sel_d = 1'b1;
          lack_d = 1'b1;
          we_d = !early_mem_write_n;
        end else if (pend_q && sys_window_request) begin
          state_d = ST_SLAVE;
          dir_d = !sys_mrdc_n_i;
          we_d = !sys_mwtc_n_i;
        end
      end
      ST_SLAVE: begin
        // cpu requests ignored here: no local ack until idle
        we_d = !sys_mwtc_n_i;
        if (sys_cmd) begin
          sel_d = 1'b1;
          ack_en_d = 1'b1;
          xack_d = sel_q && ack_done;
        end else begin
          ack_en_d = 1'b0;
          if (!pend_q) begin
            state_d = ST_IDLE;
            sel_d = 1'b0;
          end
        end
      end
      ST_LOCAL: begin
        we_d = !early_mem_write_n;
        if (cpu_window_request) begin
          lack_d = 1'b1;
        end else begin
          state_d = ST_IDLE;
          sel_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      pend_q <= 1'b0;
      sel_q <= 1'b0;
      ack_en_q <= 1'b0;
      xack_q <= 1'b0;
      dir_q <= 1'b0;
      we_q <= 1'b0;
      lack_q <= 1'b0;
      inh1_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
      sel_q <= sel_d;
      ack_en_q <= ack_en_d;
      xack_q <= xack_d;
      dir_q <= dir_d;
      we_q <= we_d;
      lack_q <= lack_d;
      inh1_q <= inh1_d;
    end
  end

  // counter runs on any select, its result only reaches the slave ack
  ack_counter u_ack_counter (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(sel_q),
    .long_i(long_ack_i),
    .done_o(ack_done)
  );

  // ------------------------------------------------------------
  // outputs from flip-flops, the two address drives decoded from state_q
  // ------------------------------------------------------------
  assign sys_inh1_n_o = !inh1_q;
  assign ack_driver_enable_n_o = !ack_en_q;
  assign shared_ram_sys_ack_n_o = !xack_q;
  assign sys_data_buffer_enable_n_o = !ack_en_q;
  assign sys_data_direction_n_o = !dir_q;
  assign slave_address_drive_n_o = !(state_q == ST_SLAVE);
  assign local_address_drive_n_o = (state_q == ST_SLAVE);
  assign shared_ram_select_n_o = !sel_q;
  assign shared_ram_write_enable_n_o = !we_q;
  assign cpu_shared_ram_ack_n_o = !lack_q;
  assign cpu_window_request_o = lack_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_no_local_ack_slave: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_SLAVE) |-> cpu_shared_ram_ack_n_o)
    else $error("local ack during slave state");
  a_xack_float_local: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_LOCAL) |-> ack_driver_enable_n_o && sys_data_buffer_enable_n_o)
    else $error("system drivers on during local access");
  a_slave_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_IDLE && pend_q && sys_window_request && !cpu_window_request)
      |=> !slave_address_drive_n_o)
    else $error("slave state not entered");
  a_select_after_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(slave_address_drive_n_o) && sys_cmd |=> !shared_ram_select_n_o)
    else $error("select late after slave entry");
  a_local_grant: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_IDLE && cpu_window_request)
      |=> !shared_ram_select_n_o && !cpu_shared_ram_ack_n_o && slave_address_drive_n_o)
    else $error("local grant wrong");
  a_pending_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sys_window_request |=> pend_q)
    else $error("pending flag not set");
  a_release_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_SLAVE && !sys_cmd && pend_q) ##1 !sys_cmd |=> state_q == ST_IDLE)
    else $error("slave not released");
  a_inhibit_two: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sys_inh2_n_i |=> sys_inh1_n_o)
    else $error("request not inhibited");
endmodule

//--- dual_port_ram_arbiter_tb.sv
`timescale 1ns/10ps
module dual_port_ram_arbiter_tb;
  import dpram_arb_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, exp_i = 0, long_i = 0, cmd_n = 1, ew_n = 1;
  logic inh2_n = 1, own_n = 1, sreq = 0, swr = 0;
  logic [ADDR_W-1:0] caddr = '0, saddr, sa;
  logic [BLOCK_SEL_W-1:0] blk = 10'h2A5;
  logic inh1, aen, xack, sdb, dir, sad, lad, sel, we, cack, creq, mrdc, mwtc;
  int num_errors = 0, comparisons = 0;
  always #5 clk_i = ~clk_i;
  dual_port_ram_arbiter DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .expansion_fitted_i(exp_i),
    .long_ack_i(long_i), .sys_window_block_i(blk), .cpu_addr_i(caddr), .cpu_mem_cmd_n_i(cmd_n),
    .early_mem_write_n(ew_n), .sys_addr_i(saddr), .sys_mrdc_n_i(mrdc), .sys_mwtc_n_i(mwtc),
    .sys_inh2_n_i(inh2_n), .own_master_address_drive_n(own_n), .sys_inh1_n_o(inh1),
    .ack_driver_enable_n_o(aen), .shared_ram_sys_ack_n_o(xack),
    .sys_data_buffer_enable_n_o(sdb), .sys_data_direction_n_o(dir),
    .slave_address_drive_n_o(sad), .local_address_drive_n_o(lad), .shared_ram_select_n_o(sel),
    .shared_ram_write_enable_n_o(we), .cpu_shared_ram_ack_n_o(cack), .cpu_window_request_o(creq));
  sys_master_model master (.clk_i(clk_i), .req_i(sreq), .wr_i(swr), .addr_i(sa), .xack_n_i(xack),
    .xack_en_n_i(aen), .addr_o(saddr), .mrdc_n_o(mrdc), .mwtc_n_o(mwtc));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return sel;
      1: return xack;
      2: return cack;
      default: return sad;
    endcase
  endfunction
  // bounded wait for an active-low output; the count of edges comes back
  task automatic wl(input int k, input int b, output int n);
    n = 0;
    while (sig(k) !== 1'b0) begin
      if (n == b) begin
        chk(0, "wait timed out");
        final_report();
      end
      tick();
      n++;
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sys_cycle(input logic wr, input int lat);
    int n;
    swr = wr;
    sa = {blk, 10'h013};
    sreq = 1;
    wl(0, 40, n);
    chk(sad === 0 && lad === 1 && inh1 === 0, "slave drive");
    chk(aen === 0 && sdb === 0 && dir === wr && we === !wr, "slave controls");
    wl(1, 60, n);
    chk(n == lat, "ack latency");
    tick(2);
    chk(aen === 1 && sdb === 1 && sel === 0, "drivers released");
    tick();
    chk(sel === 1 && sad === 1, "back to idle");
    sreq = 0;
    tick();
    $display("sys cycle done");
  endtask
  task automatic cpu_cycle(input logic [ADDR_W-1:0] a, input logic hit, input logic wr);
    int n;
    caddr = a;
    ew_n = !wr;
    cmd_n = 0;
    if (hit) begin
      wl(2, 3, n);
      chk(sel === 0 && creq === 1 && we === !wr, "cpu grant");
      chk(aen === 1 && sdb === 1, "system side off");
    end else begin
      tick(4);
      chk(cack === 1 && creq === 0 && sel === 1, "no cpu hit");
    end
    cmd_n = 1;
    tick(2);
    chk(cack === 1 && sel === 1, "cpu end");
    $display("cpu cycle done");
  endtask
  task automatic blocked(input logic i2, input logic om, input logic [BLOCK_SEL_W-1:0] b);
    inh2_n = i2;
    own_n = om;
    sa = {b, 10'h3FF};
    sreq = 1;
    tick(6);
    chk(inh1 === 1 && sel === 1 && sad === 1, "request not suppressed");
    sreq = 0;
    inh2_n = 1;
    own_n = 1;
    tick(2);
    $display("inhibit case done");
  endtask
  task automatic lockout();
    int n;
    sa = {blk, 10'h001};
    sreq = 1;
    wl(3, 10, n);
    cmd_n = 0;
    caddr = 20'h00C00;
    n = 0;
    while (sad === 0 && n < 60) begin
      chk(cack === 1, "cpu ack withheld");
      tick();
      n++;
    end
    chk(n < 60, "slave cycle did not end");
    sreq = 0;
    wl(2, 2, n);
    chk(n == 1, "deferred cpu start");
    cmd_n = 1;
    tick(3);
    $display("lockout done");
  endtask
  task automatic priority_tie();
    caddr = 20'h00C00;
    cmd_n = 0;
    sa = {blk, 10'h002};
    sreq = 1;
    tick(6);
    chk(cack === 0 && sad === 1, "cpu wins");
    cmd_n = 1;
    // let the local select drop before waiting for the slave select
    tick(2);
    sys_cycle(1'b0, 3);
  endtask
  initial begin
    tick(20);
    sys_rst_i = 0;
    chk(inh1 === 1 && aen === 1 && sel === 1 && cack === 1 && lad === 0, "reset");
    sys_cycle(1'b0, 3);
    sys_cycle(1'b1, 3);
    long_i = 1;
    sys_cycle(1'b1, 35);
    long_i = 0;
    blocked(1'b0, 1'b1, blk);
    blocked(1'b1, 1'b0, blk);
    blocked(1'b1, 1'b1, blk + 10'h001);
    blk = 10'h3FF;
    sys_cycle(1'b0, 3);
    cpu_cycle(20'h00C00, 1'b1, 1'b1);
    cpu_cycle(20'h00FFF, 1'b1, 1'b0);
    cpu_cycle(20'h01C00, 1'b0, 1'b0);
    exp_i = 1;
    cpu_cycle(20'h01C00, 1'b1, 1'b1);
    cpu_cycle(20'h00C00, 1'b0, 1'b0);
    exp_i = 0;
    priority_tie();
    lockout();
    final_report();
  end
endmodule

//--- sys_master_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// system bus master: holds its command until acknowledge
// ------------------------------------------------------------
module sys_master_model
  import dpram_arb_pkg::*;
(
  // clock
  input wire logic clk_i,
  // control from bench
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // bus
  input wire logic xack_n_i,
  input wire logic xack_en_n_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic mrdc_n_o,
  output logic mwtc_n_o
);
  logic busy_q;
  logic held_q;
  logic [ADDR_W-1:0] last_q;
  always_ff @(posedge clk_i) begin
    if (!req_i) begin
      busy_q <= 1'b0;
      held_q <= 1'b0;
    end else if (!busy_q && !held_q) begin
      busy_q <= 1'b1;
      last_q <= addr_i;
    end else if (busy_q && !xack_en_n_i && !xack_n_i) begin
      busy_q <= 1'b0;
      held_q <= 1'b1;
    end
  end
  // released address lines carry no stale value
  assign addr_o = busy_q ? last_q : ~last_q;
  assign mrdc_n_o = !(busy_q && !wr_i);
  assign mwtc_n_o = !(busy_q && wr_i);
endmodule
